// >>> rtl/seek_servo_pkg.sv
// shared constants and types for the seek servo sequencer
`default_nettype none
package seek_servo_pkg;
	localparam int unsigned TRACK_W = 11;
	localparam int unsigned GRAY_W = 4;
	localparam int unsigned VEL_W = 8;
	localparam int unsigned SAMP_W = 10;
	localparam int unsigned ERR_W = 11;
	localparam int unsigned VEL_TBL_N = 8;
	localparam logic [TRACK_W-1:0] TRACK_ZERO = 11'h000;
	localparam logic [GRAY_W-1:0] GRAY_ZERO = 4'h0;
	localparam logic [VEL_W-1:0] VEL_ZERO = 8'h00;
	localparam logic [ERR_W-1:0] ERR_ZERO = 11'h000;
	// velocity table, indexed by log2 band of remaining tracks
	localparam logic [VEL_W-1:0] VEL_TBL [VEL_TBL_N] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h60, 8'h80, 8'hc0};
	typedef enum logic [1:0] {
		ST_CENTER = 2'b01,
		ST_SEEK = 2'b10
	} servo_mode_t;
	typedef struct packed {
		logic [SAMP_W-1:0] inner;
		logic [SAMP_W-1:0] outer;
	} burst_t;
	typedef struct packed {
		logic seek_sel;
		logic [ERR_W-1:0] servo_error_a;
		logic [ERR_W-1:0] servo_error_b;
	} drive_t;
endpackage
`default_nettype wire

// >>> rtl/gray_cross_counter.sv
// gray code track crossing increment extractor
`default_nettype none
module gray_cross_counter
	import seek_servo_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// sample in
	input wire logic i_load,
	input wire logic i_sample,
	input wire logic [GRAY_W-1:0] i_gray,
	// increment out
	output logic [GRAY_W-1:0] o_incr
);
	logic [GRAY_W-1:0] bin;
	logic [GRAY_W-1:0] prev_q;
	// gray to binary, one bit per stage
	genvar g;
	generate
		for (g = 0; g < GRAY_W; g++) begin : g_bin
			assign bin[g] = ^i_gray[GRAY_W-1:g];
		end
	endgenerate
	// modulo 16 difference wraps naturally in four bits
	assign o_incr = i_load ? GRAY_ZERO : GRAY_W'(bin - prev_q);
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			prev_q <= GRAY_ZERO;
		end else if (i_load || i_sample) begin
			prev_q <= bin;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/seek_servo_sequencer.sv
// head positioning servo sequencer: centering and seek modes
// What this block does
// - the sequencer has exactly two modes, centering and seek.
// - with no seek in progress it stays in centering mode.
// - an accepted seek command moves it from centering into seek mode.
// - entering seek loads the track count and a table velocity goes to the dac.
// - the path selector routes seek velocity error in seek and centering error otherwise.
// - in seek mode crossings are found by sampling the 4 bit gray code at each sector start.
// - each sample decrements the remaining count by the tracks crossed since the last one.
// - in seek mode the digitised tachometer velocity is read to supervise speed.
// - velocity setpoints shrink as the remaining count nears zero.
// - on reaching the destination the sequencer returns to centering.
// - centering error is inner minus outer burst, sent out as two servo errors.
// - the burst difference is also digitised for the supervising processor.
// - the gray code is a modulo 16 value so wrap from 15 to 0 counts right.
`default_nettype none
module seek_servo_sequencer
	import seek_servo_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// seek command
	input wire logic i_seek_cmd,
	input wire logic [TRACK_W-1:0] i_track_count,
	output logic o_seek_busy,
	output logic o_seek_done,
	// sector servo samples
	input wire logic i_sector_start,
	input wire logic [GRAY_W-1:0] i_gray_code,
	input wire burst_t i_burst,
	// tachometer adc
	input wire logic [VEL_W-1:0] i_tach_velocity,
	output logic o_overspeed,
	// velocity dac and motor path
	output logic [VEL_W-1:0] o_velocity_setpoint,
	output drive_t o_drive,
	// monitor for processor
	output logic [ERR_W-1:0] o_position_error
);
	servo_mode_t mode_q, mode_d;
	logic [TRACK_W-1:0] remain_q;
	logic [GRAY_W-1:0] incr;
	logic load;
	logic sample;
	logic arrive;
	logic [TRACK_W-1:0] remain_next;
	logic [2:0] band;
	logic [VEL_W-1:0] setpoint_q;
	logic [ERR_W-1:0] position_error;
	logic [ERR_W-1:0] vel_error;
	logic [ERR_W-1:0] err_q;
	logic seek_sel_q;
	logic done_q;
	logic over_q;

	assign load = (mode_q == ST_CENTER) && i_seek_cmd;
	assign sample = (mode_q == ST_SEEK) && i_sector_start;
	assign remain_next = ({7'h00, incr} >= remain_q) ? TRACK_ZERO : TRACK_W'(remain_q - {7'h00, incr});
	assign arrive = sample && (remain_next == TRACK_ZERO);

	gray_cross_counter u_cross (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_load(load),
		.i_sample(sample),
		.i_gray(i_gray_code),
		.o_incr(incr)
	);

	// mode machine
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			ST_CENTER: begin
				if (load && (i_track_count != TRACK_ZERO)) begin
					mode_d = ST_SEEK;
				end
			end
			ST_SEEK: begin
				if (arrive) begin
					mode_d = ST_CENTER;
				end
			end
			default: begin
				mode_d = ST_CENTER;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			mode_q <= ST_CENTER;
		end else begin
			mode_q <= mode_d;
		end
	end

	// remaining track counter
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			remain_q <= TRACK_ZERO;
		end else if (load) begin
			remain_q <= i_track_count;
		end else if (sample) begin
			remain_q <= remain_next;
		end
	end

	// log2 band of remaining count picks table entry
	always_comb begin
		band = 3'h0;
		for (int i = 3; i < TRACK_W; i++) begin
			if (remain_q[i]) begin
				band = (i - 3 > 7) ? 3'h7 : 3'(i - 3);
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			setpoint_q <= VEL_ZERO;
		end else if (mode_q == ST_SEEK && mode_d == ST_SEEK) begin
			setpoint_q <= VEL_TBL[band];
		end else begin
			setpoint_q <= VEL_ZERO;
		end
	end

	// velocity and position errors
	assign position_error = ERR_W'({1'b0, i_burst.inner} - {1'b0, i_burst.outer});
	assign vel_error = ERR_W'({3'h0, setpoint_q} - {3'h0, i_tach_velocity});

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			err_q <= ERR_ZERO;
			seek_sel_q <= 1'b0;
			o_position_error <= ERR_ZERO;
			done_q <= 1'b0;
			over_q <= 1'b0;
		end else begin
			seek_sel_q <= (mode_q == ST_SEEK);
			err_q <= (mode_q == ST_SEEK) ? vel_error : position_error;
			o_position_error <= position_error;
			done_q <= arrive;
			over_q <= (mode_q == ST_SEEK) && (i_tach_velocity > setpoint_q);
		end
	end

	assign o_drive.seek_sel = seek_sel_q;
	assign o_drive.servo_error_a = err_q;
	assign o_drive.servo_error_b = ERR_W'(-err_q);
	assign o_velocity_setpoint = setpoint_q;
	assign o_seek_busy = (mode_q == ST_SEEK);
	assign o_seek_done = done_q;
	assign o_overspeed = over_q;

	seek_enter_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		load && i_track_count != TRACK_ZERO |=> o_seek_busy) else $error("seek not entered");
	center_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!o_seek_busy && !i_seek_cmd |=> !o_seek_busy) else $error("left centering without command");
	arrive_exit_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		arrive |=> !o_seek_busy && o_seek_done) else $error("no return on arrival");
	path_sel_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		o_seek_busy |=> o_drive.seek_sel) else $error("path selector wrong in seek");
	count_dec_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		sample && !arrive |=> remain_q == $past(remain_q) - {7'h00, $past(incr)}) else $error("count not decremented");
	wrap_incr_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!load && u_cross.prev_q == 4'hf && u_cross.bin == 4'h0 |-> incr == 4'h1) else $error("wrap miscounted");
	center_err_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!o_seek_busy |=> o_drive.servo_error_a == $past(position_error)) else $error("centering error not routed");
	monitor_diff_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		1'b1 |=> o_position_error == $past(position_error)) else $error("monitor difference wrong");
	slow_near_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		o_seek_busy && remain_q < 11'h008 && !arrive |=> o_velocity_setpoint == VEL_TBL[0]) else $error("no slowdown");

	// seek entry and exit steps
	sequence seek_start_s;
		load && (i_track_count != TRACK_ZERO);
	endsequence
	sequence seek_run_s;
		o_seek_busy && !o_drive.seek_sel ##1 o_drive.seek_sel;
	endsequence
	sequence arrive_s;
		sample && (remain_next == TRACK_ZERO);
	endsequence
	sequence settle_s;
		o_seek_done && !o_seek_busy
		##1 !o_seek_done && !o_drive.seek_sel && (o_velocity_setpoint == VEL_ZERO);
	endsequence

	seek_launch_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		seek_start_s |=> seek_run_s) else $error("seek entry steps wrong");
	arrive_settle_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		arrive_s |=> settle_s) else $error("return to centering steps wrong");
	count_load_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		seek_start_s |=> remain_q == $past(i_track_count)) else $error("track count not loaded");
	gray_ref_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		seek_start_s |=> u_cross.prev_q == $past(u_cross.bin)) else $error("gray reference not taken");

	// refusal, routing and speed checks
	zero_refuse_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		load && i_track_count == TRACK_ZERO |=> !o_seek_busy) else $error("zero count seek entered");
	seek_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		o_seek_busy && !i_sector_start |=> $stable(remain_q)) else $error("count moved without sample");
	sector_ignore_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!o_seek_busy && !i_seek_cmd |=> $stable(remain_q)) else $error("count moved in centering");
	done_pulse_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		o_seek_done |=> !o_seek_done) else $error("done longer than one cycle");
	center_setpoint_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!o_seek_busy |=> o_velocity_setpoint == VEL_ZERO) else $error("setpoint in centering");
	seek_err_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		o_seek_busy |=> o_drive.servo_error_a == $past(vel_error)) else $error("seek error not routed");
	overspeed_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		o_seek_busy && (i_tach_velocity > o_velocity_setpoint) |=> o_overspeed) else $error("overspeed missed");
	center_calm_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!o_seek_busy |=> !o_overspeed) else $error("overspeed in centering");
endmodule
`default_nettype wire

// >>> verif/seek_far_model.sv
// far side model: sector servo fields, carriage position and tachometer
`default_nettype none
module seek_far_model
	import seek_servo_pkg::*;
(
	// clock
	input wire logic i_ref_clk,
	// motor path and test controls
	input wire logic i_seek_sel,
	input wire logic [GRAY_W-1:0] i_step,
	input wire logic [VEL_W-1:0] i_tach,
	// sensed values
	output logic o_sector_start,
	output logic [GRAY_W-1:0] o_gray_code,
	output logic [VEL_W-1:0] o_tach_velocity,
	output int o_pos
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] slot_q = 4'h0;
	logic [3:0] bin;
	initial begin
		o_pos = 0;
		o_sector_start = 1'b0;
		o_gray_code = 4'h0;
		o_tach_velocity = 8'h00;
	end
	// carriage moves step tracks per sector while the seek drive is selected
	always @(negedge i_ref_clk) begin
		slot_q <= slot_q + 4'h1;
		o_sector_start <= (slot_q == 4'hf);
		o_tach_velocity <= i_seek_sel ? i_tach : 8'h00;
		if (slot_q == 4'hf && i_seek_sel) begin
			o_pos = o_pos + int'(i_step);
			bin = o_pos[3:0];
			o_gray_code <= bin ^ (bin >> 1);
		end
	end
endmodule
`default_nettype wire

// >>> verif/seek_servo_sequencer_tb_top.sv
// self-checking bench for the seek servo sequencer
`default_nettype none
module seek_servo_sequencer_tb_top;
	import seek_servo_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic cmd = 1'b0;
	logic [TRACK_W-1:0] cnt = 11'h000;
	logic busy, done, sect, ovr;
	logic [GRAY_W-1:0] gray;
	logic [GRAY_W-1:0] step = 4'h1;
	logic [VEL_W-1:0] tach, tach_in = 8'h00;
	logic [VEL_W-1:0] sp;
	burst_t burst = '0;
	drive_t drv;
	logic [ERR_W-1:0] perr;
	int pos;
	int n_mismatch = 0;
	int num_checks = 0;
	seek_servo_sequencer dut_u (.i_ref_clk(clk), .i_srst(srst), .i_seek_cmd(cmd), .i_track_count(cnt),
		.o_seek_busy(busy), .o_seek_done(done), .i_sector_start(sect), .i_gray_code(gray), .i_burst(burst),
		.i_tach_velocity(tach), .o_overspeed(ovr), .o_velocity_setpoint(sp), .o_drive(drv),
		.o_position_error(perr));
	seek_far_model far_u (.i_ref_clk(clk), .i_seek_sel(drv.seek_sel), .i_step(step), .i_tach(tach_in),
		.o_sector_start(sect), .o_gray_code(gray), .o_tach_velocity(tach), .o_pos(pos));
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic center_test(input logic [9:0] inr, input logic [9:0] otr, input logic [ERR_W-1:0] e);
		burst = '{inner: inr, outer: otr};
		repeat (3) @(negedge clk);
		check(perr, e);
		check(drv.servo_error_a, e);
		check(drv.servo_error_b, ERR_W'(-e));
		check(drv.seek_sel, 1'b0);
		$display("centering test done");
	endtask
	task automatic zero_count_test();
		cnt = 11'h000;
		cmd = 1'b1;
		@(negedge clk);
		cmd = 1'b0;
		repeat (3) @(negedge clk);
		check(busy, 1'b0);
		check(drv.seek_sel, 1'b0);
		$display("zero count test done");
	endtask
	task automatic reset_test();
		cnt = 11'h064;
		cmd = 1'b1;
		@(negedge clk);
		cmd = 1'b0;
		repeat (3) @(negedge clk);
		check(busy, 1'b1);
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		check(busy, 1'b0);
		check(sp, VEL_ZERO);
		check(drv.seek_sel, 1'b0);
		check(drv.servo_error_b, ERR_ZERO);
		check(perr, ERR_ZERO);
		check(done, 1'b0);
		check(ovr, 1'b0);
		@(negedge clk);
		check(busy, 1'b0);
		$display("reset test done");
	endtask
	task automatic seek_test(input logic [TRACK_W-1:0] n, input logic [3:0] stp, input logic [VEL_W-1:0] sp0,
		input logic [VEL_W-1:0] tv);
		int p0;
		int k;
		logic [VEL_W-1:0] prev;
		step = stp;
		tach_in = tv;
		@(posedge clk);
		while (sect !== 1'b1) @(posedge clk);
		@(negedge clk);
		p0 = pos;
		cmd = 1'b1;
		cnt = n;
		@(negedge clk);
		cnt = 11'h001;
		@(negedge clk);
		cmd = 1'b0;
		check(busy, 1'b1);
		@(negedge clk);
		check(sp, sp0);
		check(drv.seek_sel, 1'b1);
		check(ovr, tv > sp0);
		check(drv.servo_error_a, ERR_W'({3'h0, sp0} - {3'h0, tv}));
		prev = sp;
		for (k = 0; k < 3000 && done !== 1'b1; k++) begin
			@(negedge clk);
			if (busy === 1'b1) check(sp > prev, 1'b0);
			prev = sp;
		end
		check(done, 1'b1);
		check(busy, 1'b0);
		check(pos - p0, ((n + stp - 1) / stp) * stp);
		@(negedge clk);
		check(done, 1'b0);
		@(negedge clk);
		check(sp, VEL_ZERO);
		check(drv.seek_sel, 1'b0);
		tach_in = 8'h00;
		$display("seek test done");
	endtask
	initial begin
		repeat (2) @(negedge clk);
		srst = 1'b0;
		check(busy, 1'b0);
		check(sp, VEL_ZERO);
		center_test(10'h300, 10'h100, 11'h200);
		center_test(10'h100, 10'h300, 11'h600);
		zero_count_test();
		reset_test();
		seek_test(11'd20, 4'h3, VEL_TBL[1], 8'hff);
		seek_test(11'd5, 4'h1, VEL_TBL[0], 8'h00);
		seek_test(11'd2047, 4'hf, VEL_TBL[7], 8'hff);
		report_and_stop();
	end
	initial begin
		#(12000 * 20);
		n_mismatch++;
		report_and_stop();
	end
endmodule
`default_nettype wire
